//--- dv/dpc_host_model.sv
`timescale 1ns/10ps
module dpc_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Test control
  input wire logic go,
  input wire logic [23:0] word,
  // Device side
  input wire logic sampleReady,
  input wire logic dataClockOut,
  input wire logic lane,
  output logic sampleValid,
  output logic [23:0] sampleData,
  output logic spiSerialOut,
  output logic [29:0] cap,
  output logic [5:0] bits
);
  logic dclkPrev;
  // Outside an offer the bus shows the inverse, so a stale word cannot pass
  assign sampleData = sampleValid ? word : ~word;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sampleValid <= 1'b0;
      spiSerialOut <= 1'b0;
      dclkPrev <= 1'b0;
      cap <= 30'h0;
      bits <= 6'h0;
    end else begin
      spiSerialOut <= ~spiSerialOut;
      dclkPrev <= dataClockOut;
      if (go) begin
        sampleValid <= 1'b1;
        cap <= 30'h0;
        bits <= 6'h0;
      end else if (sampleValid && sampleReady) begin
        sampleValid <= 1'b0;
      end
      // Lane is stable at the data clock rising edge
      if (dataClockOut && !dclkPrev) begin
        cap <= {cap[28:0], lane};
        bits <= bits + 6'h1;
      end
    end
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errTotal++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tb_top import dpc_pkg::*;;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic [23:0] sampleData;
  logic sampleValid, sampleReady, spiSerialOut, sharedSerialOutPin, lane;
  logic dataClockOut, frameActive, bufferedClockOut, refGainCorrOn, go = 1'b0;
  logic ce = 1'b1;
  dpc_alias_e antialiasModeSel;
  logic [29:0] cap;
  logic [5:0] bits;
  logic [23:0] word = 24'hA5C3E1;
  logic [5:0] crcA;
  logic b0;
  int errTotal = 0;
  int testsRun = 0;
  always #50 clock = ~clock;
  dpc_config_regs i_dpc_config_regs (.clock(clock), .rst_b(rst_b), .ce(ce),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .sampleData(sampleData), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .spiSerialOut(spiSerialOut),
    .sharedSerialOutPin(sharedSerialOutPin), .conversionDataLaneZero(lane),
    .dataClockOut(dataClockOut), .frameActive(frameActive),
    .bufferedClockOut(bufferedClockOut), .antialiasModeSel(antialiasModeSel),
    .refGainCorrOn(refGainCorrOn));
  dpc_host_model i_dpc_host_model (.clock(clock), .rst_b(rst_b), .go(go), .word(word),
    .sampleReady(sampleReady), .dataClockOut(dataClockOut), .lane(lane),
    .sampleValid(sampleValid), .sampleData(sampleData), .spiSerialOut(spiSerialOut),
    .cap(cap), .bits(bits));
  task automatic finish_test();
    if (errTotal == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clock);
    #10 regWrEn = 1'b0;
    // One idle edge so a following call never re-raises the strobe in the same step
    @(posedge clock);
    #10;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clock);
    #10 regRdEn = 1'b0;
    `CHK("regRdData", e, regRdData)
    @(posedge clock);
    #10;
  endtask
  function automatic logic [5:0] crcRun(logic [5:0] s, int n);
    logic fb;
    for (int i = 23; i > 23 - n; i--) begin
      fb = s[5] ^ word[i];
      s = {s[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
    end
    return s;
  endfunction
  // One frame; the shared pin must repeat its selected source one cycle late
  task automatic frame(input int n, input int len, input logic [29:0] e, input logic src,
                       input logic [7:0] mid);
    int cnt;
    int bad;
    logic seen, pl, ps;
    cnt = 0;
    bad = 0;
    seen = 1'b0;
    go = 1'b1;
    @(posedge clock);
    #10 go = 1'b0;
    for (int i = 0; i < 5000 && !(seen && !frameActive); i++) begin
      pl = lane;
      ps = spiSerialOut;
      regWrEn = (cnt == 4 && mid != 8'h00);
      regAddr = 8'h11;
      regWrData = mid;
      @(posedge clock);
      #10;
      if (frameActive) begin
        seen = 1'b1;
        cnt++;
      end
      if (sharedSerialOutPin !== (src ? pl : ps)) bad++;
    end
    `CHK("pin", 0, bad)
    `CHK("frameLen", len, cnt)
    `CHK("bitCount", n[5:0], bits)
    `CHK("frameBits", e, cap)
  endtask
  initial begin
    #2000000;
    errTotal++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clock);
    #10 rst_b = 1'b1;
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h0F);
    `CHK("aaMode", ALIAS_MODE_SECOND, antialiasModeSel)
    `CHK("gainCorr", 1'b1, refGainCorrOn)
    b0 = bufferedClockOut;
    @(posedge clock);
    #10 `CHK("bclkToggle", ~b0, bufferedClockOut)
    wr(8'h10, 8'h00);
    @(posedge clock);
    #10 `CHK("bclkOff", 1'b0, bufferedClockOut)
    `CHK("aaMode", ALIAS_MODE_FIRST, antialiasModeSel)
    `CHK("gainCorr", 1'b0, refGainCorrOn)
    rd(8'h12, 8'h00);
    // Clock enable low must freeze the register file
    ce = 1'b0;
    wr(8'h10, 8'h0A);
    ce = 1'b1;
    `CHK("aaModeFrozen", ALIAS_MODE_FIRST, antialiasModeSel)
    `CHK("gainFrozen", 1'b0, refGainCorrOn)
    rd(8'h10, 8'h00);
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'hBF);
    wr(8'h11, 8'h00);
    frame(16, 32, 30'(word[23:8]), 1'b0, 8'h00);
    wr(8'h11, 8'h20);
    frame(24, 48, 30'(word), 1'b0, 8'h00);
    wr(8'h10, 8'h04);
    wr(8'h11, 8'h31);
    frame(30, 120, {word, crcRun(6'h3F, 24)}, 1'b1, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h10);
    crcA = crcRun(6'h3F, 16);
    repeat (2) frame(22, 44, 30'({word[23:8], crcA}), 1'b0, 8'h00);
    wr(8'h11, 8'h90);
    frame(22, 44, 30'({word[23:8], crcA}), 1'b0, 8'h92);
    frame(22, 176, 30'({word[23:8], crcRun(crcA, 16)}), 1'b0, 8'h00);
    finish_test();
  end
endmodule

//--- logic/dpc_clk_div.sv
`timescale 1ns/10ps
`include "dpc_map.svh"
module dpc_clk_div import dpc_pkg::*; #(
  parameter int SEL_W = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic [SEL_W-1:0] divSel,
  // Outputs
  output logic dataClockOut,
  output logic fallTick
);
  localparam int CNT_W = (1 << SEL_W);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic data_clock_out_q, data_clock_out_d;
  logic [CNT_W-1:0] halfLast;
  logic hit;

  always_comb begin
    halfLast = (CNT_W'(1) << divSel) - CNT_W'(1);
    hit = run && (cnt_q == halfLast);
    cnt_d = cnt_q;
    data_clock_out_d = data_clock_out_q;
    if (!run) begin
      cnt_d = '0;
      data_clock_out_d = 1'b0;
    end else if (hit) begin
      // Each code step doubles the half period [RULE9]
      cnt_d = '0;
      data_clock_out_d = !data_clock_out_q;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      data_clock_out_q <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      data_clock_out_q <= data_clock_out_d;
    end
  end

  assign dataClockOut = data_clock_out_q;
  assign fallTick = hit && data_clock_out_q;

  AST_DIV_ONE_HALF: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE9]
    (run && divSel == 4'h1 && $rose(data_clock_out_q)) |-> (run && divSel == 4'h1) [*1] ##0
      data_clock_out_q [*2] ##1 (!data_clock_out_q || !run))
    else $error("Divider code 1 half period is not two cycles");
endmodule

//--- logic/dpc_config_regs.sv
`timescale 1ns/10ps
`include "dpc_map.svh"
// Functional notes
// RULE1 - Device setup bit 3 picks the first or second antialias mode.
// RULE2 - Bit 2 routes serial register data or data lane zero to the shared pin.
// RULE3 - Bit 1 turns reference gain correction on when set.
// RULE4 - Bit 0 lets the buffered clock out run; cleared it stays low.
// RULE5 - Upper four bits of device setup always read back zero.
// RULE6 - Seed method 0 reloads the CRC seed at each frame end.
// RULE7 - Seed method 1 keeps the previous frame CRC as the next seed.
// RULE8 - Frame code picks 16 or 24 data bits, optionally followed by 6 CRC bits.
// RULE9 - Divider code 0 is fastest; each increment halves the data clock.
// RULE10 - Device setup sits at 0x10 and both registers reset to zero.
// RULE11 - Frame, seed and divider changes apply only at the next frame start.
module dpc_config_regs import dpc_pkg::*; #(
  parameter int SAMPLE_W = 24,
  parameter logic [5:0] CRC_SEED = `DPC_CRC_SEED,
  parameter logic [5:0] CRC_POLY = `DPC_CRC_POLY
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // Register port from the serial core
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // Conversion samples
  input wire logic [SAMPLE_W-1:0] sampleData,
  input wire logic sampleValid,
  output logic sampleReady,
  // Serial core data out
  input wire logic spiSerialOut,
  // Pins and mode levels
  output logic sharedSerialOutPin,
  output logic conversionDataLaneZero,
  output logic dataClockOut,
  output logic frameActive,
  output logic bufferedClockOut,
  output dpc_alias_e antialiasModeSel,
  output logic refGainCorrOn
);
  dpc_dev_s dev_q, dev_d;
  dpc_frame_s frm_q, frm_d;
  dpc_frame_s act_q, act_d;
  dpc_state_e st_q, st_d;
  logic [SAMPLE_W-1:0] shift_q, shift_d;
  logic [5:0] crc_q, crc_d;
  logic [4:0] bitCnt_q, bitCnt_d;
  logic lane_q, lane_d;
  logic pin_q, pin_d;
  logic bclk_q, bclk_d;
  logic [7:0] rd_q, rd_d;
  logic fallTick;
  logic [4:0] dataBits, totalBits;
  logic [5:0] crcNext;
  logic frameDone;

  function automatic logic [5:0] crcStep(input logic [5:0] c, input logic b);
    logic fb;
    fb = c[5] ^ b;
    crcStep = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
  endfunction

  // Register file
  always_comb begin
    dev_d = dev_q;
    frm_d = frm_q;
    rd_d = rd_q;
    if (regWrEn && regAddr == `DPC_ADDR_CFG1) begin
      // Reserved upper bits are not stored [RULE5]
      dev_d.antialiasModeSel = dpc_alias_e'(regWrData[`DPC_BIT_AA]); // [RULE1]
      dev_d.serialOutPinSource = regWrData[`DPC_BIT_SRC]; // [RULE2]
      dev_d.refGainCorrOn = regWrData[`DPC_BIT_GAIN]; // [RULE3]
      dev_d.bufferedClockOutOn = regWrData[`DPC_BIT_BCLK]; // [RULE4]
    end
    if (regWrEn && regAddr == `DPC_ADDR_FRAME) begin
      frm_d.crcSeedMethod = regWrData[`DPC_BIT_SEED];
      frm_d.frameFmt = dpc_fmt_e'(regWrData[`DPC_FMT_HI:`DPC_FMT_LO]); // [RULE8]
      frm_d.dataClockDivSel = regWrData[`DPC_DIV_HI:`DPC_DIV_LO]; // [RULE9]
    end
    if (regRdEn) begin
      case (regAddr)
        `DPC_ADDR_CFG1: rd_d = {4'h0, dev_q}; // [RULE5]
        `DPC_ADDR_FRAME: rd_d = {frm_q.crcSeedMethod, 1'b0, frm_q.frameFmt,
                                 frm_q.dataClockDivSel};
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dev_q <= dpc_dev_s'(4'(`DPC_CFG1_RST)); // [RULE10]
      frm_q <= dpc_frame_s'(7'(`DPC_FRAME_RST)); // [RULE10]
      rd_q <= 8'h00;
    end else if (ce) begin
      dev_q <= dev_d;
      frm_q <= frm_d;
      rd_q <= rd_d;
    end
  end

  dpc_clk_div #(
    .SEL_W(4)
  ) u_div (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .run(st_q == ST_SHIFT),
    .divSel(act_q.dataClockDivSel),
    .dataClockOut(dataClockOut),
    .fallTick(fallTick)
  );

  // Frame engine; bits change on the falling data clock so the host samples on the rise
  always_comb begin
    dataBits = act_q.frameFmt[1] ? `DPC_D24_BITS : `DPC_D16_BITS; // [RULE8]
    totalBits = dataBits + (act_q.frameFmt[0] ? `DPC_CRC_BITS : 5'h00); // [RULE8]
    crcNext = crcStep(crc_q, shift_q[SAMPLE_W-1]);
    frameDone = (st_q == ST_SHIFT) && fallTick && (bitCnt_q == totalBits - 5'h01);
    st_d = st_q;
    act_d = act_q;
    shift_d = shift_q;
    crc_d = crc_q;
    bitCnt_d = bitCnt_q;
    case (st_q)
      ST_IDLE: begin
        if (sampleValid) begin
          // Shadow copy keeps a running frame intact [RULE11]
          act_d = frm_q;
          st_d = ST_SHIFT;
          bitCnt_d = 5'h00;
          shift_d = frm_q.frameFmt[1] ? sampleData : {sampleData[SAMPLE_W-1:8], 8'h00};
        end
      end
      ST_SHIFT: begin
        if (fallTick) begin
          if (bitCnt_q < dataBits) begin
            crc_d = crcNext;
          end
          if (bitCnt_q == dataBits - 5'h01) begin
            shift_d = {crcNext, {(SAMPLE_W-6){1'b0}}};
          end else begin
            shift_d = {shift_q[SAMPLE_W-2:0], 1'b0};
          end
          bitCnt_d = bitCnt_q + 5'h01;
          if (frameDone) begin
            st_d = ST_IDLE;
            if (!act_q.crcSeedMethod) begin
              crc_d = CRC_SEED; // [RULE6]
            end
            // Otherwise the frame result carries into the next frame [RULE7]
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    lane_d = (st_d == ST_SHIFT) ? shift_d[SAMPLE_W-1] : 1'b0;
    // Registered mux adds one cycle to either source on the shared pin
    pin_d = dev_q.serialOutPinSource ? lane_q : spiSerialOut; // [RULE2]
    bclk_d = dev_q.bufferedClockOutOn ? !bclk_q : 1'b0; // [RULE4]
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      act_q <= dpc_frame_s'(7'(`DPC_FRAME_RST));
      shift_q <= '0;
      crc_q <= CRC_SEED;
      bitCnt_q <= 5'h00;
      lane_q <= 1'b0;
      pin_q <= 1'b0;
      bclk_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      act_q <= act_d;
      shift_q <= shift_d;
      crc_q <= crc_d;
      bitCnt_q <= bitCnt_d;
      lane_q <= lane_d;
      pin_q <= pin_d;
      bclk_q <= bclk_d;
    end
  end

  assign regRdData = rd_q;
  assign sampleReady = (st_q == ST_IDLE);
  assign sharedSerialOutPin = pin_q;
  assign conversionDataLaneZero = lane_q;
  assign frameActive = (st_q == ST_SHIFT);
  assign bufferedClockOut = bclk_q;
  assign antialiasModeSel = dev_q.antialiasModeSel;
  assign refGainCorrOn = dev_q.refGainCorrOn;

  AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE5]
    (regRdEn && regAddr == `DPC_ADDR_CFG1) |=> (regRdData[7:4] == 4'h0))
    else $error("Reserved device setup bits read nonzero");
  AST_AA_WRITE: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE1]
    (regWrEn && regAddr == `DPC_ADDR_CFG1) |=>
      (antialiasModeSel == dpc_alias_e'($past(regWrData[3]))))
    else $error("Antialias mode does not follow write");
  AST_PIN_SOURCE: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE2]
    ##1 (sharedSerialOutPin == ($past(dev_q.serialOutPinSource) ?
      $past(conversionDataLaneZero) : $past(spiSerialOut))))
    else $error("Shared pin source wrong");
  AST_GAIN_WRITE: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE3]
    (regWrEn && regAddr == `DPC_ADDR_CFG1) ##1 !(regWrEn && regAddr == `DPC_ADDR_CFG1)
      |-> (refGainCorrOn == $past(regWrData[1])))
    else $error("Gain correction enable does not hold written value");
  AST_BCLK_OFF: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE4]
    !dev_q.bufferedClockOutOn |=> !bufferedClockOut)
    else $error("Buffered clock runs while disabled");
  AST_SEED_RELOAD: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE6]
    (frameDone && !act_q.crcSeedMethod) |=> (crc_q == CRC_SEED))
    else $error("CRC not reseeded at frame end");
  AST_SEED_KEEP: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE7]
    (frameDone && act_q.crcSeedMethod && act_q.frameFmt[0]) |=> $stable(crc_q))
    else $error("CRC reinitialised between frames");
  AST_FRAME_LEN16: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE8]
    ($rose(frameActive) && act_q.frameFmt == FMT_D16 && act_q.dataClockDivSel == 4'h0)
      |-> ##31 frameActive ##1 !frameActive)
    else $error("16-bit frame at fastest clock is not 32 cycles");
  AST_CFG_HOLD: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE11]
    (frameActive && $past(frameActive)) |-> $stable(act_q))
    else $error("Frame settings changed mid frame");
  AST_RESET_ZERO: assert property (@(posedge clock) disable iff (!rst_b || !ce) // [RULE10]
    $rose(rst_b) |-> (dev_q == 4'h0 && frm_q == 7'h00))
    else $error("Registers not zero after reset");
endmodule

//--- logic/dpc_map.svh
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
`define DPC_ADDR_CFG1 8'h10
`define DPC_ADDR_FRAME 8'h11
`define DPC_CFG1_RST 8'h00
`define DPC_FRAME_RST 8'h00
`define DPC_BIT_AA 3
`define DPC_BIT_SRC 2
`define DPC_BIT_GAIN 1
`define DPC_BIT_BCLK 0
`define DPC_BIT_SEED 7
`define DPC_FMT_HI 5
`define DPC_FMT_LO 4
`define DPC_DIV_HI 3
`define DPC_DIV_LO 0
`define DPC_D16_BITS 5'h10
`define DPC_D24_BITS 5'h18
`define DPC_CRC_BITS 5'h06
`define DPC_CRC_SEED 6'h3F
`define DPC_CRC_POLY 6'h03
`endif

//--- logic/dpc_pkg.sv
package dpc_pkg;
  typedef enum logic [1:0] {
    FMT_D16 = 2'b00,
    FMT_D16_CRC = 2'b01,
    FMT_D24 = 2'b10,
    FMT_D24_CRC = 2'b11
  } dpc_fmt_e;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } dpc_state_e;
  typedef enum logic {
    ALIAS_MODE_FIRST = 1'b0,
    ALIAS_MODE_SECOND = 1'b1
  } dpc_alias_e;
  typedef struct packed {
    dpc_alias_e antialiasModeSel;
    logic serialOutPinSource;
    logic refGainCorrOn;
    logic bufferedClockOutOn;
  } dpc_dev_s;
  typedef struct packed {
    logic crcSeedMethod;
    dpc_fmt_e frameFmt;
    logic [3:0] dataClockDivSel;
  } dpc_frame_s;
endpackage
